// ==== core/ugas_pkg.sv ====
// Shared constants and types for the unsolicited grant scheduler pair
package ugas_pkg;
  localparam int AGW = 4;
  localparam int SZW = 8;
  localparam int TMW = 16;
  localparam int QCW = 8;
  localparam int CLK_HZ = 10_000_000;
  localparam int NOM_INTERVAL_MS = 10;
  localparam int POLL_INTERVAL_MS = 5;
  localparam int GRANT_JITTER_US = 1000;
  localparam int INTERVAL_CYC = NOM_INTERVAL_MS * (CLK_HZ / 1000);
  localparam int POLL_CYC = POLL_INTERVAL_MS * (CLK_HZ / 1000);
  localparam int JITTER_CYC = GRANT_JITTER_US * (CLK_HZ / 1000000);
  localparam int EXTRA_SPACING = 100;
  localparam logic [AGW-1:0] RST_BURST = 4'h2;
  localparam logic [AGW-1:0] RST_MAXG = 4'h4;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BURST = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_GCOUNT = 8'h0C;
  localparam int CTRL_EN = 0;
  localparam int CTRL_MAXG_LSB = 8;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_QI = 4;
  localparam int ST_GPI_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {CM_OFF = 3'b001, CM_POLLED = 3'b010, CM_UNSOL = 3'b100} ugas_cm_mode_e;
  typedef enum logic [1:0] {HE_POLL = 2'b01, HE_GRANT = 2'b10} ugas_he_mode_e;
endpackage

// ==== core/ugas_link_if.sv ====
// Link between the modem end and the headend scheduler end
`timescale 1ns/1ns
interface ugas_link_if;
  logic grant;
  logic poll;
  logic pkt_valid;
  logic [ugas_pkg::AGW-1:0] pkt_active_grants;
  logic pkt_queue_ind;
  logic req_valid;
  logic [ugas_pkg::SZW-1:0] req_size;
  modport cm
  (
    input grant,
    input poll,
    output pkt_valid,
    output pkt_active_grants,
    output pkt_queue_ind,
    output req_valid,
    output req_size
  );
  modport hub
  (
    output grant,
    output poll,
    input pkt_valid,
    input pkt_active_grants,
    input pkt_queue_ind,
    input req_valid,
    input req_size
  );
endinterface

// ==== core/ugas_cm.sv ====
// Modem end: activity detection, grant use and grant count reporting
`timescale 1ns/1ns
module ugas_cm #(
  parameter int NSUB = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  ugas_link_if.cm lnk,
  input wire logic cfg_enable,
  input wire logic [ugas_pkg::AGW-1:0] cfg_max_grants,
  input wire logic [ugas_pkg::SZW-1:0] cfg_grant_size,
  input wire logic [ugas_pkg::TMW-1:0] cfg_timeout,
  input wire logic [ugas_pkg::QCW-1:0] cfg_qthresh,
  input wire logic [NSUB-1:0] sub_arrive,
  output logic [2:0] cm_mode,
  output logic [ugas_pkg::AGW-1:0] cm_need,
  output logic [ugas_pkg::QCW-1:0] cm_queue
);
  typedef struct packed {
    ugas_pkg::ugas_cm_mode_e mode;
    logic [NSUB-1:0][ugas_pkg::TMW-1:0] tmr;
    logic [ugas_pkg::QCW-1:0] qcnt;
    logic [ugas_pkg::AGW-1:0] need;
    logic pkt_valid;
    logic [ugas_pkg::AGW-1:0] pkt_ag;
    logic pkt_qi;
    logic req_valid;
    logic [ugas_pkg::SZW-1:0] req_size;
  } ugas_cm_s;

  ugas_cm_s s_q;
  ugas_cm_s s_d;

  always_comb
  begin
    logic [ugas_pkg::AGW-1:0] act;
    logic [ugas_pkg::QCW-1:0] arr;
    logic send;
    act = '0;
    arr = '0;
    send = 1'b0;
    s_d = s_q;
    s_d.pkt_valid = 1'b0;
    s_d.req_valid = 1'b0;
    // Per-subflow activity timer; arrival reloads it and marks active from the next cycle
    for (int i = 0; i < NSUB; i++)
    begin
      if (sub_arrive[i])
      begin
        s_d.tmr[i] = cfg_timeout;
        arr = arr + 1'b1;
      end
      else if (s_q.tmr[i] != '0)
      begin
        s_d.tmr[i] = s_q.tmr[i] - 1'b1;
      end
      if (s_q.tmr[i] != '0)
      begin
        act = act + 1'b1;
      end
    end
    // Never ask beyond the provisioned ceiling
    s_d.need = (act > cfg_max_grants) ? cfg_max_grants : act;
    if (!cfg_enable)
    begin
      s_d.mode = ugas_pkg::CM_OFF;
    end
    else
    begin
      unique case (s_q.mode)
        ugas_pkg::CM_OFF:
        begin
          s_d.mode = ugas_pkg::CM_POLLED;
        end
        ugas_pkg::CM_POLLED:
        begin
          if (lnk.grant && (s_q.need != '0 || s_q.qcnt != '0))
          begin
            // Zero-count packet may have been missed: grants still flowing
            send = 1'b1;
            s_d.pkt_ag = s_q.need;
            s_d.mode = ugas_pkg::CM_UNSOL;
          end
          else if (lnk.poll && s_q.need != '0)
          begin
            s_d.req_valid = 1'b1;
            s_d.req_size = cfg_grant_size;
          end
        end
        ugas_pkg::CM_UNSOL:
        begin
          if (lnk.grant)
          begin
            send = 1'b1;
            s_d.pkt_ag = s_q.need;
            if (s_q.need == '0)
            begin
              s_d.mode = ugas_pkg::CM_POLLED;
            end
          end
        end
      endcase
    end
    s_d.pkt_valid = send;
    s_d.qcnt = s_q.qcnt + arr - ((send && s_q.qcnt != '0) ? 1'b1 : 1'b0);
    // Backlog from clock mismatch or a lost map raises the indicator
    s_d.pkt_qi = (s_q.qcnt > cfg_qthresh);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '{mode: ugas_pkg::CM_OFF, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lnk.pkt_valid = s_q.pkt_valid;
  assign lnk.pkt_active_grants = s_q.pkt_ag;
  assign lnk.pkt_queue_ind = s_q.pkt_qi;
  assign lnk.req_valid = s_q.req_valid;
  assign lnk.req_size = s_q.req_size;
  assign cm_mode = s_q.mode;
  assign cm_need = s_q.need;
  assign cm_queue = s_q.qcnt;
endmodule // ugas_cm

// ==== core/ugas_hub.sv ====
// Headend end: grant and poll scheduling with an AHB-Lite control slave
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Functional notes
// - Grant interval equals application packet interval
// - Several grants per interval form shared pool
// - Single grant stays within tolerated jitter
// - Last grant of group within jitter
// - Interval boundary never exchanged between ends
// - Modem raises queue indicator on backlog
// - Extra grants at most one per hundred
// - Extra grants continue until indicator drops
// - Police downstream slightly above provisioned rate (not done in this block)
// - Poll when inactive, grant when active
// - Every granted packet carries needed count
// - Requested count never above provisioned maximum
// - Polled modem requests exactly one grant
// - Larger count reported from first packet
// - Added grant comes with extra burst
// - Final zero-count packet, then stop sending
// - Zero count stops grants, back to polling
// - Resume by request in a poll
// - Ignore request size, restart configured grants
// - Modem resumes from polls or grants
// - Activity timer per subflow sets count
module ugas_hub #(
  parameter int unsigned INTERVAL_CYC = ugas_pkg::INTERVAL_CYC,
  parameter int unsigned POLL_CYC = ugas_pkg::POLL_CYC,
  parameter int unsigned JITTER_CYC = ugas_pkg::JITTER_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  ugas_link_if.hub lnk,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic hub_active
);
  localparam int IW = $clog2(INTERVAL_CYC + 1);
  localparam int PW = $clog2(POLL_CYC + 1);
  localparam int AGW = ugas_pkg::AGW;
  localparam logic [IW-1:0] ITV_LAST = IW'(INTERVAL_CYC - 1);
  localparam logic [PW-1:0] POLL_LAST = PW'(POLL_CYC - 1);
  localparam logic [6:0] SPACING = 7'(ugas_pkg::EXTRA_SPACING);

  typedef struct packed {
    ugas_pkg::ugas_he_mode_e mode;
    logic en;
    logic [AGW-1:0] maxg;
    logic [AGW-1:0] burst;
    logic [IW-1:0] itv;
    logic [PW-1:0] pcnt;
    logic [AGW-1:0] gpi;
    logic [AGW-1:0] pend;
    logic [AGW-1:0] xpend;
    logic [6:0] since;
    logic qi;
    logic [31:0] gcount;
    logic grant;
    logic poll;
    logic active;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } ugas_hub_s;

  ugas_hub_s s_q;
  ugas_hub_s s_d;

  function automatic logic [31:0] reg_read(input ugas_hub_s s, input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      ugas_pkg::A_CTRL:
      begin
        v[ugas_pkg::CTRL_EN] = s.en;
        v[ugas_pkg::CTRL_MAXG_LSB +: AGW] = s.maxg;
      end
      ugas_pkg::A_BURST: v[AGW-1:0] = s.burst;
      ugas_pkg::A_STATUS:
      begin
        v[ugas_pkg::ST_MODE_LSB +: 2] = s.mode;
        v[ugas_pkg::ST_QI] = s.qi;
        v[ugas_pkg::ST_GPI_LSB +: AGW] = s.gpi;
      end
      ugas_pkg::A_GCOUNT: v = s.gcount;
      default: v = '0;
    endcase
    return v;
  endfunction

  always_comb
  begin
    logic take;
    logic regular;
    logic [AGW-1:0] ag;
    take = hsel && hready && (htrans == ugas_pkg::HTRANS_NONSEQ);
    regular = 1'b0;
    ag = lnk.pkt_active_grants;
    s_d = s_q;
    s_d.grant = 1'b0;
    s_d.poll = 1'b0;
    // Zero-wait slave: read data fetched in the address phase
    s_d.wr_pend = take && hwrite;
    if (take)
    begin
      s_d.wr_addr = haddr[7:0];
      s_d.rdata = reg_read(s_q, haddr[7:0]);
    end
    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_addr)
        ugas_pkg::A_CTRL:
        begin
          s_d.en = hwdata[ugas_pkg::CTRL_EN];
          s_d.maxg = hwdata[ugas_pkg::CTRL_MAXG_LSB +: AGW];
        end
        ugas_pkg::A_BURST: s_d.burst = hwdata[AGW-1:0];
        ugas_pkg::A_GCOUNT: s_d.gcount = '0;
        default: s_d.gcount = s_q.gcount;
      endcase
    end
    if (!s_q.en)
    begin
      s_d.mode = ugas_pkg::HE_POLL;
      s_d.gpi = '0;
      s_d.pend = '0;
      s_d.xpend = '0;
      s_d.pcnt = '0;
    end
    else
    begin
      unique case (s_q.mode)
        ugas_pkg::HE_POLL:
        begin
          s_d.pcnt = (s_q.pcnt == POLL_LAST) ? '0 : s_q.pcnt + 1'b1;
          s_d.poll = (s_q.pcnt == '0);
          if (lnk.req_valid)
          begin
            // Requested size is ignored; one configured grant per interval
            s_d.mode = ugas_pkg::HE_GRANT;
            s_d.gpi = 4'h1;
            s_d.itv = '0;
            s_d.xpend = s_q.burst;
          end
        end
        ugas_pkg::HE_GRANT:
        begin
          // Private interval phase; the modem never sees the boundary
          s_d.itv = (s_q.itv == ITV_LAST) ? '0 : s_q.itv + 1'b1;
          if (s_q.itv == '0)
          begin
            // Group issued back to back so last grant lands early
            s_d.pend = s_q.gpi;
          end
          else if (s_q.pend != '0)
          begin
            s_d.grant = 1'b1;
            s_d.pend = s_q.pend - 1'b1;
            regular = 1'b1;
          end
          else if (s_q.xpend != '0)
          begin
            s_d.grant = 1'b1;
            s_d.xpend = s_q.xpend - 1'b1;
          end
          else if (s_q.qi && s_q.since >= SPACING)
          begin
            s_d.grant = 1'b1;
            s_d.since = '0;
          end
          if (regular && s_q.since < SPACING)
          begin
            s_d.since = s_q.since + 1'b1;
          end
          if (lnk.pkt_valid)
          begin
            s_d.qi = lnk.pkt_queue_ind;
            if (ag == '0)
            begin
              s_d.mode = ugas_pkg::HE_POLL;
              s_d.gpi = '0;
              s_d.pend = '0;
              s_d.xpend = '0;
              s_d.pcnt = '0;
            end
            else
            begin
              s_d.gpi = (ag > s_q.maxg) ? s_q.maxg : ag;
              if (ag > s_q.gpi)
              begin
                s_d.xpend = s_q.burst;
              end
            end
          end
        end
      endcase
    end
    // Grant in the clearing cycle still counts, on top of the cleared value
    if (s_d.grant)
    begin
      s_d.gcount = s_d.gcount + 1'b1;
    end
    s_d.active = (s_d.mode == ugas_pkg::HE_GRANT);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '{mode: ugas_pkg::HE_POLL, maxg: ugas_pkg::RST_MAXG, burst: ugas_pkg::RST_BURST,
               default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Downstream policing lives outside this block; no downstream path here
  assign lnk.grant = s_q.grant;
  assign lnk.poll = s_q.poll;
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hub_active = s_q.active;
endmodule // ugas_hub

// ==== dv/ugas_checker.sv ====
// Link checks for the modem and headend scheduler pair
`timescale 1ns/1ns
module ugas_checker #(
  parameter int MAXG = 4,
  parameter int GSIZE = 1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic grant,
  input wire logic poll,
  input wire logic pkt_valid,
  input wire logic [ugas_pkg::AGW-1:0] pkt_active_grants,
  input wire logic pkt_queue_ind,
  input wire logic req_valid,
  input wire logic [ugas_pkg::SZW-1:0] req_size
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_pkt_on_grant: assert property (pkt_valid |-> $past(grant))
    else $error("packet without grant");
  a_req_on_poll: assert property (req_valid |-> $past(poll))
    else $error("request without poll");
  a_count_capped: assert property (pkt_valid |-> pkt_active_grants <= MAXG)
    else $error("grant count above maximum");
  a_req_size: assert property (req_valid |-> req_size == GSIZE)
    else $error("request size wrong");
  a_grant_after_req: assert property (req_valid |-> ##3 grant)
    else $error("no grant after request");
  a_first_count: assert property (req_valid |-> ##4 (pkt_valid && pkt_active_grants != 0))
    else $error("first packet count wrong");
  a_stop_after_zero: assert property (pkt_valid && pkt_active_grants == 0 |=> !pkt_valid [*4])
    else $error("packet after final zero");
  a_zero_ends_grants: assert property (pkt_valid && pkt_active_grants == 0 |-> ##2 !grant [*8])
    else $error("grants after zero count");
  a_poll_spacing: assert property (poll |=> !poll [*8])
    else $error("polls too close");
  // Request, zero count and queue backlog are the paths worth seeing
  cover property (req_valid);
  cover property (pkt_valid && pkt_active_grants == 0);
  cover property (pkt_valid && pkt_queue_ind);
endmodule // ugas_checker

// ==== dv/test_unsolicited_grant_activity_scheduler.sv ====
// Bench for the modem and headend scheduler pair
`timescale 1ns/1ns
module test_unsolicited_grant_activity_scheduler;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ugas_row_s;
  logic hclk, hresetn, hsel, hwrite, hready, hub_active, cfg_enable, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cm_mode;
  logic [3:0] cfg_max_grants, sub_arrive, cm_need;
  logic [7:0] cfg_grant_size, cfg_qthresh, cm_queue;
  logic [15:0] cfg_timeout;
  int errors, samples_checked;
  ugas_row_s rows [4] = '{
    '{ugas_pkg::A_BURST, 32'h0000000F, 32'h0000000F},
    '{ugas_pkg::A_BURST, 32'h00000002, 32'h00000002},
    '{8'h10, 32'hFFFFFFFF, 32'h00000000},
    '{ugas_pkg::A_CTRL, 32'h00000401, 32'h00000401}};
  ugas_link_if lnk();
  ugas_cm #(.NSUB(4)) i_ugas_cm (.hclk(hclk), .hresetn(hresetn), .lnk(lnk),
    .cfg_enable(cfg_enable), .cfg_max_grants(cfg_max_grants), .cfg_grant_size(cfg_grant_size),
    .cfg_timeout(cfg_timeout), .cfg_qthresh(cfg_qthresh), .sub_arrive(sub_arrive),
    .cm_mode(cm_mode), .cm_need(cm_need), .cm_queue(cm_queue));
  // Short interval and poll period keep the run small
  ugas_hub #(.INTERVAL_CYC(40), .POLL_CYC(20), .JITTER_CYC(10)) i_ugas_hub (.hclk(hclk),
    .hresetn(hresetn), .lnk(lnk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .hub_active(hub_active));
  ugas_checker #(.MAXG(3), .GSIZE(8'h5A)) i_ugas_checker (.hclk(hclk), .hresetn(hresetn),
    .grant(lnk.grant), .poll(lnk.poll), .pkt_valid(lnk.pkt_valid),
    .pkt_active_grants(lnk.pkt_active_grants), .pkt_queue_ind(lnk.pkt_queue_ind),
    .req_valid(lnk.req_valid), .req_size(lnk.req_size));
  always #50 hclk = ~hclk;
  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
    samples_checked++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= ugas_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Kind 0 waits for a packet carrying count v, kind 1 for hub_active equal to bit 0 of v
  function automatic logic hit(input int k, input logic [3:0] v);
    if (k == 0)
      return lnk.pkt_valid === 1'b1 && lnk.pkt_active_grants === v;
    return hub_active === v[0];
  endfunction
  task automatic await(input int k, input logic [3:0] v, input int n);
    int i;
    i = 0;
    @(posedge hclk);
    while (!hit(k, v) && i < n)
    begin
      @(posedge hclk);
      i++;
    end
    chk(32'h1, 32'(hit(k, v)), "wait");
  endtask
  task automatic pulse(input logic [3:0] m, input int n);
    @(posedge hclk);
    sub_arrive <= m;
    repeat (n) @(posedge hclk);
    sub_arrive <= 4'h0;
  endtask
  task report_and_stop;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (8000) @(posedge hclk);
    errors++;
    report_and_stop;
  end
  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    hsize = 3'h2; cfg_enable = 0; cfg_max_grants = 4'h3; cfg_grant_size = 8'h5A;
    cfg_timeout = 16'h0200; cfg_qthresh = 8'h01; sub_arrive = 4'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    cfg_enable <= 1'b1;
    foreach (rows[i])
    begin
      ahb(1'b1, rows[i].a, rows[i].w);
      ahb(1'b0, rows[i].a, 32'h0);
      chk(rows[i].e, rd, "register");
    end
    repeat (50) @(posedge hclk);
    ahb(1'b0, ugas_pkg::A_STATUS, 32'h0);
    chk(32'h00000001, rd & 32'h00000013, "idle status");
    chk(32'h0, 32'(hresp), "response");
    pulse(4'h1, 1);
    await(1, 4'h1, 60);
    await(0, 4'h1, 60);
    pulse(4'h1, 6);
    await(0, 4'h1, 60);
    chk(32'h1, 32'(lnk.pkt_queue_ind), "queue ind");
    pulse(4'hF, 1);
    await(0, 4'h3, 200);
    ahb(1'b0, ugas_pkg::A_STATUS, 32'h0);
    chk(32'h00000302, rd & 32'h00000F03, "grant status");
    await(0, 4'h0, 2000);
    chk(32'h0, 32'(lnk.pkt_queue_ind), "queue ind off");
    chk(32'h0, 32'(cm_queue), "queue drained");
    await(1, 4'h0, 10);
    chk(32'(ugas_pkg::CM_POLLED), 32'(cm_mode), "modem mode");
    ahb(1'b1, ugas_pkg::A_GCOUNT, 32'h0);
    ahb(1'b0, ugas_pkg::A_GCOUNT, 32'h0);
    chk(32'h0, rd, "grant count");
    pulse(4'h3, 1);
    await(0, 4'h2, 200);
    chk(32'h2, 32'(cm_need), "need");
    // Lowered ceiling must clip the reported count within 100 cycles
    cfg_max_grants <= 4'h1;
    await(0, 4'h1, 100);
    chk(32'h1, 32'(cm_need), "need capped");
    hresetn <= 1'b0;
    @(posedge hclk);
    chk(32'h0, 32'({lnk.grant, lnk.poll, lnk.pkt_valid, lnk.req_valid, hub_active, cm_need,
      cm_queue}), "reset");
    chk(32'h1, 32'(cm_mode), "reset mode");
    hresetn <= 1'b1;
    ahb(1'b0, ugas_pkg::A_CTRL, 32'h0);
    chk(32'h00000400, rd, "ctrl reset");
    ahb(1'b0, ugas_pkg::A_BURST, 32'h0);
    chk(32'h00000002, rd, "burst reset");
    report_and_stop;
  end
endmodule // test_unsolicited_grant_activity_scheduler
